// file: common/htbk_pkg.sv
// shared constants for the heater break alarm block
package htbk_pkg;
   // timing: evaluation needs an unbroken on-period of this length
   localparam int unsigned CLK_HZ     = 200_000_000;
   localparam int unsigned ON_MIN_MS  = 190;
   localparam int unsigned ON_MIN_CYC = ON_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned ON_CNT_W   = 26;

   // current and threshold values are in tenths of an ampere
   localparam int unsigned CUR_W      = 10;
   localparam logic [9:0]  THR_OFF    = 10'h000;  // 0.0 A: alarm held off
   localparam logic [9:0]  THR_FORCE  = 10'h1F4;  // 50.0 A: alarm forced on
   localparam logic [9:0]  CUR_OVER   = 10'h226;  // 55.0 A: monitor over range
   localparam logic [15:0] CUR_OVER_RD = 16'hFFFF;

   // register byte addresses
   localparam logic [4:0] REG_CTRL    = 5'h00;
   localparam logic [4:0] REG_THR     = 5'h04;
   localparam logic [4:0] REG_CUR     = 5'h08;
   localparam logic [4:0] REG_STAT    = 5'h0C;
   localparam logic [4:0] REG_IRQ_ST  = 5'h10;
   localparam logic [4:0] REG_IRQ_EN  = 5'h14;
   localparam logic [4:0] REG_IRQ_CLR = 5'h18;

   // control register fields
   localparam int unsigned CTRL_HOLD   = 0;
   localparam int unsigned CTRL_PULSED = 1;
   localparam int unsigned CTRL_AUX_LO = 2;
   localparam logic [1:0]  AUX_NONE    = 2'h0;
   localparam logic [1:0]  AUX_ONE     = 2'h1;
   localparam logic [1:0]  AUX_TWO     = 2'h2;

   // status register fields
   localparam int unsigned ST_ALARM   = 0;
   localparam int unsigned ST_MEAS_OK = 1;
   localparam int unsigned ST_ON_OK   = 2;

   // interrupt event bits
   localparam int unsigned IRQ_W   = 3;
   localparam int unsigned EV_RISE = 0;
   localparam int unsigned EV_FALL = 1;
   localparam int unsigned EV_OVER = 2;
endpackage

// file: design/htbk_irq.sv
// sticky event status, enable mask and level interrupt output
`timescale 1ns/10ps
`default_nettype none
module htbk_irq (
   input  wire logic                       ref_clk_i,
   input  wire logic                       srst_i,
   input  wire logic [htbk_pkg::IRQ_W-1:0] event_i,
   input  wire logic                       en_we_i,
   input  wire logic                       clr_we_i,
   input  wire logic [htbk_pkg::IRQ_W-1:0] wdata_i,
   output var  logic [htbk_pkg::IRQ_W-1:0] status_o,
   output var  logic [htbk_pkg::IRQ_W-1:0] enable_o,
   output var  logic                       irq_o
);
   import htbk_pkg::*;

   typedef struct packed {
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] enable;
      logic             irq;
   } htbk_irq_t;

   htbk_irq_t r;
   htbk_irq_t next_r;

   // a set in the same cycle as its clear wins, so no event is lost
   always_comb begin
      next_r = r;
      if (clr_we_i) begin
         next_r.status = r.status & ~wdata_i;
      end
      next_r.status = next_r.status | event_i;
      if (en_we_i) begin
         next_r.enable = wdata_i;
      end
      next_r.irq = |(next_r.status & next_r.enable);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign status_o = r.status;
   assign enable_o = r.enable;
   assign irq_o    = r.irq;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   set_wins_a: assert property (event_i[EV_RISE] |=> status_o[EV_RISE])
      else $error("event lost against a clear");
   irq_level_a: assert property (irq_o == |(status_o & enable_o))
      else $error("interrupt level disagrees with status and mask");
endmodule // htbk_irq
`default_nettype wire

// file: design/htbk_ontime.sv
// qualifies control output on-periods that last long enough to evaluate
`timescale 1ns/10ps
`default_nettype none
module htbk_ontime #(
   parameter int unsigned MIN_CYC = htbk_pkg::ON_MIN_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic heat_on_i,
   output var  logic on_ok_o
);
   import htbk_pkg::*;

   localparam logic [ON_CNT_W-1:0] MIN_CNT = ON_CNT_W'(MIN_CYC);

   typedef struct packed {
      logic [ON_CNT_W-1:0] cnt;
      logic                ok;
   } htbk_ontime_t;

   htbk_ontime_t r;
   htbk_ontime_t next_r;

   // any gap in the on-period restarts the count; saturates on long pulses
   always_comb begin
      next_r = r;
      if (!heat_on_i) begin
         next_r.cnt = '0;
      end else if (r.cnt != '1) begin
         next_r.cnt = r.cnt + 1'b1;
      end
      next_r.ok = heat_on_i && (next_r.cnt >= MIN_CNT);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign on_ok_o = r.ok;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   on_len_a: assert property (on_ok_o |-> r.cnt >= MIN_CNT)
      else $error("on-period qualified before minimum length");
   on_gap_a: assert property (!heat_on_i |=> !on_ok_o)
      else $error("qualification survived an output gap");
endmodule // htbk_ontime
`default_nettype wire

// file: design/htbk_top.sv
// heater break alarm: current capture, threshold compare, hold, routing, registers
//
// Operation
// - detection and the alarm exist only while the heat output is set up as pulsed.
// - the alarm is driven onto auxiliary output one or two, whichever is selected.
// - the alarm is raised when the measured current is below the threshold.
// - threshold takes 0.1 to 49.9 A; 0.0 holds the alarm off, 50.0 forces it on.
// - with hold on, a raised alarm stays until threshold 0.0 is written or reset; the code also releases it when the pulsed setting is cleared.
// - the alarm never alters the control output, which passes on unchanged.
// - only unbroken on-periods of 190 ms or more are evaluated.
// - the measured current is readable as a heater current monitor value.
// - at 55.0 A or more the monitor reads an over-range code instead of a value.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module htbk_top #(
   parameter int unsigned MIN_CYC = htbk_pkg::ON_MIN_CYC
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       srst_i,
   input  wire logic [4:0]                 avs_address_i,
   input  wire logic                       avs_read_i,
   input  wire logic                       avs_write_i,
   input  wire logic [31:0]                avs_writedata_i,
   input  wire logic [3:0]                 avs_byteenable_i,
   output var  logic [31:0]                avs_readdata_o,
   output var  logic                       avs_waitrequest_o,
   input  wire logic                       heat_on_i,
   input  wire logic [htbk_pkg::CUR_W-1:0] sample_i,
   input  wire logic                       sample_valid_i,
   output var  logic                       ctrl_out_o,
   output var  logic                       aux1_o,
   output var  logic                       aux2_o,
   output var  logic                       irq_o
);
   import htbk_pkg::*;

   typedef struct packed {
      logic             waitreq;
      logic [31:0]      rdata;
      logic             hold_en;
      logic             pulsed;
      logic [1:0]       aux_sel;
      logic [CUR_W-1:0] thr;
      logic [CUR_W-1:0] meas;
      logic             meas_ok;
      logic             alarm;
      logic             aux1;
      logic             aux2;
      logic             ctrl_out;
   } htbk_top_t;

   htbk_top_t        r;
   htbk_top_t        next_r;
   logic             on_ok;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_enable;
   logic [IRQ_W-1:0] events;
   logic             irq_en_we;
   logic             irq_clr_we;
   logic             wr_go;
   logic             cap;
   logic             eval;

   // over-range test, shared by readback and the event
   function automatic logic is_over(input logic [CUR_W-1:0] v);
      return v >= CUR_OVER;
   endfunction

   // monitor value as software sees it
   function automatic logic [15:0] cur_view(input logic [CUR_W-1:0] v);
      return is_over(v) ? CUR_OVER_RD : {6'h00, v};
   endfunction

   htbk_ontime #(
      .MIN_CYC   (MIN_CYC)
   ) u_ontime (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .heat_on_i (heat_on_i),
      .on_ok_o   (on_ok)
   );

   htbk_irq u_irq (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .event_i   (events),
      .en_we_i   (irq_en_we),
      .clr_we_i  (irq_clr_we),
      .wdata_i   (avs_writedata_i[IRQ_W-1:0]),
      .status_o  (irq_status),
      .enable_o  (irq_enable),
      .irq_o     (irq_o)
   );

   // writes land on the edge where the master sees waitrequest low
   assign wr_go      = avs_write_i && !r.waitreq;
   assign irq_en_we  = wr_go && avs_address_i == REG_IRQ_EN && avs_byteenable_i[0];
   assign irq_clr_we = wr_go && avs_address_i == REG_IRQ_CLR && avs_byteenable_i[0];

   // capture only while the heater is driven; off-phases read no current
   assign cap  = heat_on_i && sample_valid_i;
   assign eval = r.pulsed && on_ok && cap;

   // alarm transitions and over-range samples raise interrupt events
   assign events[EV_RISE] = next_r.alarm && !r.alarm;
   assign events[EV_FALL] = !next_r.alarm && r.alarm;
   assign events[EV_OVER] = cap && is_over(sample_i);

   // detection, routing and register access
   always_comb begin
      logic [31:0] rd;
      rd     = '0;
      next_r = r;

      // one wait cycle per access keeps read data registered
      // costs two cycles per access, but no read path is combinational
      next_r.waitreq = !((avs_read_i || avs_write_i) && r.waitreq);
      case (avs_address_i)
         REG_CTRL: begin
            rd[CTRL_HOLD]                 = r.hold_en;
            rd[CTRL_PULSED]               = r.pulsed;
            rd[CTRL_AUX_LO+1:CTRL_AUX_LO] = r.aux_sel;
         end
         REG_THR: begin
            rd[CUR_W-1:0] = r.thr;
         end
         REG_CUR: begin
            rd[15:0] = cur_view(r.meas);
         end
         REG_STAT: begin
            rd[ST_ALARM]   = r.alarm;
            rd[ST_MEAS_OK] = r.meas_ok;
            rd[ST_ON_OK]   = on_ok;
         end
         REG_IRQ_ST: begin
            rd[IRQ_W-1:0] = irq_status;
         end
         REG_IRQ_EN: begin
            rd[IRQ_W-1:0] = irq_enable;
         end
         default: begin
            rd = '0; // clear register and unmapped addresses read zero
         end
      endcase
      if (avs_read_i && r.waitreq) begin
         next_r.rdata = rd;
      end

      // last on-phase sample stays for readback; the compare uses the live sample_i
      if (cap) begin
         next_r.meas    = sample_i;
         next_r.meas_ok = 1'b1;
      end

      // threshold extremes override the measurement
      if (!r.pulsed) begin
         next_r.alarm = 1'b0;
      end else if (r.thr == THR_OFF) begin
         next_r.alarm = 1'b0;
      end else if (r.thr == THR_FORCE) begin
         next_r.alarm = 1'b1;
      end else if (eval) begin
         next_r.alarm = (sample_i < r.thr) || (r.hold_en && r.alarm);
      end

      // routing to the selected auxiliary output
      next_r.aux1 = next_r.alarm && r.aux_sel == AUX_ONE;
      next_r.aux2 = next_r.alarm && r.aux_sel == AUX_TWO;

      // control output is a plain retime, the alarm has no path into it
      next_r.ctrl_out = heat_on_i;

      // register writes; a threshold above 50.0 A is ignored
      if (wr_go && avs_byteenable_i[0]) begin
         if (avs_address_i == REG_CTRL) begin
            next_r.hold_en = avs_writedata_i[CTRL_HOLD];
            next_r.pulsed  = avs_writedata_i[CTRL_PULSED];
            next_r.aux_sel = avs_writedata_i[CTRL_AUX_LO+1:CTRL_AUX_LO];
         end
      end
      if (wr_go && avs_byteenable_i[1:0] == 2'h3 && avs_address_i == REG_THR) begin
         if (avs_writedata_i[15:0] <= {6'h00, THR_FORCE}) begin
            next_r.thr = avs_writedata_i[CUR_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r         <= '0;
         r.waitreq <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign avs_readdata_o    = r.rdata;
   assign avs_waitrequest_o = r.waitreq;
   assign ctrl_out_o        = r.ctrl_out;
   assign aux1_o            = r.aux1;
   assign aux2_o            = r.aux2;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   // thresholds strictly inside the range leave the decision to the compare
   logic thr_mid;
   assign thr_mid = r.thr != THR_OFF && r.thr != THR_FORCE;

   not_pulsed_a: assert property (!r.pulsed |=> !r.alarm)
      else $error("alarm raised without pulsed heat output");
   aux_one_a: assert property (r.aux_sel == AUX_ONE && $stable(r.aux_sel)
                               |-> aux1_o == r.alarm && !aux2_o)
      else $error("alarm not routed to auxiliary one");
   aux_two_a: assert property (r.aux_sel == AUX_TWO && $stable(r.aux_sel)
                               |-> aux2_o == r.alarm && !aux1_o)
      else $error("alarm not routed to auxiliary two");
   below_thr_a: assert property (eval && thr_mid && sample_i < r.thr |=> r.alarm)
      else $error("low current did not raise the alarm");
   above_thr_a: assert property (eval && thr_mid && !r.hold_en && sample_i >= r.thr
                                 |=> !r.alarm)
      else $error("alarm raised at or above threshold");
   thr_off_a: assert property (r.thr == THR_OFF |=> !r.alarm)
      else $error("alarm not held off at zero threshold");
   thr_force_a: assert property (r.pulsed && r.thr == THR_FORCE |=> r.alarm)
      else $error("alarm not forced on at full threshold");
   hold_keep_a: assert property (r.hold_en && r.alarm && r.pulsed && r.thr != THR_OFF
                                 |=> r.alarm)
      else $error("held alarm released early");
   ctrl_pass_a: assert property (1'b1 |=> ctrl_out_o == $past(heat_on_i))
      else $error("control output disturbed");
   short_on_a: assert property (!on_ok && r.pulsed && thr_mid |=> $stable(r.alarm))
      else $error("short pulse changed the alarm");
   capture_a: assert property (cap |=> r.meas == $past(sample_i) && r.meas_ok)
      else $error("on-phase sample not captured");
   keep_meas_a: assert property (!heat_on_i |=> $stable(r.meas))
      else $error("measurement changed during off-phase");
   mon_over_a: assert property (avs_read_i && r.waitreq && avs_address_i == REG_CUR
                                && is_over(r.meas) |=> avs_readdata_o[15:0] == CUR_OVER_RD)
      else $error("over-range code missing");
   mon_val_a: assert property (avs_read_i && r.waitreq && avs_address_i == REG_CUR
                               && !is_over(r.meas)
                               |=> avs_readdata_o[CUR_W-1:0] == $past(r.meas))
      else $error("monitor value wrong");
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && r.waitreq
                                  |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle after request");

   // routing and gating seen at the auxiliary outputs
   aux_none_a: assert property (r.aux_sel != AUX_ONE && r.aux_sel != AUX_TWO
                                |=> !aux1_o && !aux2_o)
      else $error("alarm routed with no auxiliary output selected");
   pulsed_gate_a: assert property (!r.pulsed |=> !aux1_o && !aux2_o)
      else $error("auxiliary output raised without pulsed heat output");
   hold_clear_a: assert property (r.thr == THR_OFF |=> !aux1_o && !aux2_o)
      else $error("zero threshold left an auxiliary output raised");

   // register side: accepted writes land once, refused ones leave no trace
   thr_range_a: assert property (r.thr <= THR_FORCE)
      else $error("threshold holds a refused value");
   thr_write_a: assert property (wr_go && avs_address_i == REG_THR
                                 && avs_byteenable_i[1:0] == 2'h3
                                 && avs_writedata_i[15:0] <= {6'h00, THR_FORCE}
                                 |=> r.thr == $past(avs_writedata_i[CUR_W-1:0]))
      else $error("valid threshold write lost");
   thr_partial_a: assert property (wr_go && avs_address_i == REG_THR
                                   && avs_byteenable_i[1:0] != 2'h3 |=> $stable(r.thr))
      else $error("partial threshold write took effect");
   ctrl_write_a: assert property (wr_go && avs_address_i == REG_CTRL
                                  && avs_byteenable_i[0]
                                  |=> r.pulsed == $past(avs_writedata_i[CTRL_PULSED]))
      else $error("pulsed setting not taken");
   rdata_hold_a: assert property (!(avs_read_i && r.waitreq) |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   idle_wait_a: assert property (!avs_read_i && !avs_write_i && r.waitreq
                                 |=> avs_waitrequest_o)
      else $error("waitrequest dropped with no request");

   // event flags follow the alarm and the monitor
   meas_kept_a: assert property (r.meas_ok |=> r.meas_ok)
      else $error("measurement flag dropped");
   over_event_a: assert property (cap && is_over(sample_i) |=> irq_status[EV_OVER])
      else $error("over-range sample raised no event");
   rise_event_a: assert property ($rose(r.alarm) |-> irq_status[EV_RISE])
      else $error("alarm rise raised no event");
   fall_event_a: assert property ($fell(r.alarm) |-> irq_status[EV_FALL])
      else $error("alarm fall raised no event");
   en_write_a: assert property (irq_en_we |=> irq_enable == $past(avs_writedata_i[IRQ_W-1:0]))
      else $error("interrupt enable write not taken");
   clr_write_a: assert property (irq_clr_we && !(|events)
                                 |=> (irq_status & $past(avs_writedata_i[IRQ_W-1:0])) == '0)
      else $error("interrupt clear did not take");

   held_rise_c: cover property (r.hold_en ##0 $rose(r.alarm));
   forced_c: cover property (r.thr == THR_FORCE ##1 r.alarm);
   over_read_c: cover property (avs_readdata_o[15:0] == CUR_OVER_RD);
   irq_c: cover property ($rose(irq_o));
   short_c: cover property (heat_on_i && !on_ok ##1 !heat_on_i);
endmodule // htbk_top
`default_nettype wire

// file: verification/htbk_ct_model.sv
// current sense transformer model: strobes the heater current while heat is on
`timescale 1ns/10ps
`default_nettype none
module htbk_ct_model #(
   parameter int unsigned PERIOD = 4
) (
   input  wire logic       ref_clk_i,
   input  wire logic       heat_on_i,
   input  wire logic [9:0] level_i,
   output var  logic [9:0] sample_o,
   output var  logic       valid_o
);
   int unsigned cnt;

   // idle line is not pulled, so the model toggles it to expose stale captures
   initial begin
      cnt = 0;
      sample_o = 10'h155;
      valid_o = 1'b0;
   end

   // one single-phase on/off load, sampled only while current flows
   always @(posedge ref_clk_i) begin
      if (heat_on_i && cnt == PERIOD - 1) begin
         sample_o <= level_i;
         valid_o <= 1'b1;
      end else begin
         sample_o <= ~sample_o;
         valid_o <= 1'b0;
      end
      cnt <= heat_on_i ? (cnt + 1) % PERIOD : 0;
   end
endmodule // htbk_ct_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking testbench for the heater break alarm block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import htbk_pkg::*;
   localparam int unsigned MIN_T = 20;
   // threshold halfway between 5.0 A normal and 0.0 A broken, a 5.0 A gap
   localparam logic [9:0]  THR_A = (10'h032 + 10'h000) / 2;
   logic        ref_clk;
   logic        srst;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [3:0]  ben;
   logic [31:0] rdat;
   logic        wreq;
   logic        heat;
   logic [9:0]  level;
   logic [9:0]  smp;
   logic        smp_vld;
   logic        ctrl_out;
   logic        aux1;
   logic        aux2;
   logic        irq;
   logic        heat_q;
   logic        mon;
   logic [31:0] q;
   int          err_count;
   int          n_checks;

   htbk_top #(.MIN_CYC(MIN_T)) htbk_top_inst (
      .ref_clk_i         (ref_clk),
      .srst_i            (srst),
      .avs_address_i     (addr),
      .avs_read_i        (rd),
      .avs_write_i       (wr),
      .avs_writedata_i   (wdat),
      .avs_byteenable_i  (ben),
      .avs_readdata_o    (rdat),
      .avs_waitrequest_o (wreq),
      .heat_on_i         (heat),
      .sample_i          (smp),
      .sample_valid_i    (smp_vld),
      .ctrl_out_o        (ctrl_out),
      .aux1_o            (aux1),
      .aux2_o            (aux2),
      .irq_o             (irq)
   );

   htbk_ct_model htbk_ct_model_inst (
      .ref_clk_i (ref_clk),
      .heat_on_i (heat),
      .level_i   (level),
      .sample_o  (smp),
      .valid_o   (smp_vld)
   );

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // control output must track heat one cycle late whatever the alarm does
   always @(posedge ref_clk) begin
      if (mon) begin
         check("ctrl_out", {31'h0, ctrl_out}, {31'h0, heat_q});
      end
      heat_q <= heat;
      mon <= !srst;
   end

   // one bus access; held until waitrequest is sampled low
   // a late answer is counted, a hang is ended by the watchdog
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      addr <= a;
      wdat <= d;
      ben <= be;
      rd <= !w;
      wr <= w;
      @(posedge ref_clk);
      while (wreq !== 1'b0) begin
         @(posedge ref_clk);
         n++;
         if (n == 50) begin
            check("waitrequest", 32'h1, 32'h0);
         end
      end
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr32(input logic [4:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hF, q);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string nm);
      bus(a, 1'b0, 32'h0, 4'hF, q);
      check(nm, q, exp);
   endtask

   // outputs are registered, so let a few edges land before looking
   task automatic chk_out(input logic [2:0] e);
      repeat (3) @(posedge ref_clk);
      check("irq_aux2_aux1", {29'h0, irq, aux2, aux1}, {29'h0, e});
   endtask

   task automatic pulse(input logic [9:0] lv, input int unsigned n);
      @(posedge ref_clk);
      level <= lv;
      heat <= 1'b1;
      repeat (n) @(posedge ref_clk);
      heat <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic end_test(input string nm);
      $display("test %s done, %0d checks, %0d mismatches", nm, n_checks, err_count);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end

   initial begin
      err_count = 0;
      n_checks = 0;
      srst = 1'b1;
      addr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0;
      ben = 4'h0;
      heat = 1'b0;
      level = 10'h000;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      // every offset reads zero after reset, the unmapped 0x1C too
      check("waitrequest idle", {31'h0, wreq}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         rdc(5'(i * 4), 32'h0, "reset value");
      end
      chk_out(3'h0);
      end_test("reset");
      // threshold range ends, refused values and partial byte enables
      wr32(REG_THR, 32'h1);
      rdc(REG_THR, 32'h1, "thr 0.1");
      wr32(REG_THR, 32'h1F3);
      rdc(REG_THR, 32'h1F3, "thr 49.9");
      wr32(REG_THR, 32'h1F5);
      rdc(REG_THR, 32'h1F3, "thr 50.1 refused");
      bus(REG_THR, 1'b1, 32'h5, 4'h1, q);
      rdc(REG_THR, 32'h1F3, "thr byteenable");
      wr32(REG_THR, {22'h0, THR_A});
      end_test("threshold");
      // not pulsed: neither a low current nor a forced threshold alarms
      wr32(REG_CTRL, {28'h0, AUX_ONE, 2'h0});
      pulse(10'h00A, 40);
      rdc(REG_STAT, 32'h2, "stat not pulsed");
      wr32(REG_THR, {22'h0, THR_FORCE});
      chk_out(3'h0);
      wr32(REG_THR, {22'h0, THR_A});
      end_test("not pulsed");
      // pulsed: a pulse just short of the minimum is not judged
      wr32(REG_CTRL, {28'h0, AUX_ONE, 2'h2});
      pulse(10'h00A, MIN_T - 2);
      chk_out(3'h0);
      rdc(REG_STAT, 32'h2, "stat short pulse");
      pulse(10'h00A, 2 * MIN_T);
      chk_out(3'h1);
      rdc(REG_CUR, 32'hA, "current kept");
      rdc(REG_STAT, 32'h3, "stat alarm");
      rdc(REG_IRQ_ST, 32'h1, "irq rise");
      wr32(REG_IRQ_EN, 32'h1);
      chk_out(3'h5);
      wr32(REG_IRQ_EN, 32'h0);
      chk_out(3'h1);
      wr32(REG_IRQ_CLR, 32'h1);
      rdc(REG_IRQ_ST, 32'h0, "irq cleared");
      end_test("detect");
      // alarm moves to the second output and follows a healthy current
      wr32(REG_CTRL, {28'h0, AUX_TWO, 2'h2});
      chk_out(3'h2);
      pulse(10'h03C, 2 * MIN_T);
      chk_out(3'h0);
      rdc(REG_IRQ_ST, 32'h2, "irq fall");
      end_test("aux two");
      // hold keeps the alarm through a healthy pulse until 0.0 is written
      wr32(REG_CTRL, {28'h0, AUX_ONE, 2'h3});
      pulse(10'h00A, 2 * MIN_T);
      pulse(10'h03C, 2 * MIN_T);
      chk_out(3'h1);
      // a reset in mid-run also releases the held alarm and clears the setup
      srst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      chk_out(3'h0);
      rdc(REG_THR, 32'h0, "thr after reset");
      wr32(REG_CTRL, {28'h0, AUX_ONE, 2'h3});
      wr32(REG_THR, {22'h0, THR_A});
      pulse(10'h00A, 2 * MIN_T);
      chk_out(3'h1);
      wr32(REG_THR, 32'h0);
      chk_out(3'h0);
      pulse(10'h00A, 2 * MIN_T);
      chk_out(3'h0);
      end_test("hold");
      // forced on at 50.0 even above it, then the over-range monitor code
      wr32(REG_CTRL, {28'h0, AUX_ONE, 2'h2});
      wr32(REG_THR, {22'h0, THR_FORCE});
      pulse(10'h21C, 2 * MIN_T);
      chk_out(3'h1);
      pulse(10'h225, 2 * MIN_T);
      rdc(REG_CUR, 32'h225, "current 54.9");
      wr32(REG_IRQ_CLR, 32'h7);
      wr32(REG_IRQ_EN, 32'h4);
      rdc(REG_IRQ_EN, 32'h4, "irq enable");
      pulse(CUR_OVER, 2 * MIN_T);
      rdc(REG_CUR, {16'h0, CUR_OVER_RD}, "current 55.0");
      rdc(REG_IRQ_ST, 32'h4, "irq over");
      chk_out(3'h5);
      wr32(REG_IRQ_CLR, 32'h4);
      chk_out(3'h1);
      end_test("force and range");
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
